// >>> reconfig_controller.sv
// Controller end of the reconfiguration host port
`timescale 1ns/1ps
`default_nettype none
`include "reconfig_defines.svh"

// Contract
// RULE_01: Write begins on one-cycle write request pulse
// RULE_02: Continuous mode: one pulse writes whole image
// RULE_03: Continuous mode uses configurable image read latency
// RULE_04: Regular mode: fabric pulses once per word
// RULE_05: Busy low first cycle, then high
// RULE_06: Busy held through offset cancellation
// RULE_07: Busy high during each analog transaction
// RULE_08: Busy high while image is written
// RULE_09: Read pulse one cycle, analog mode only
// RULE_10: Read request used only with analog ports
// RULE_11: Data valid marks valid analog read-back
// RULE_12: Data valid exists only with read ports
// RULE_13: Error output reports unsupported operation
// RULE_14: Unsupported: busy low, error two cycles
// RULE_15: Fabric waits for busy low before requesting
module reconfig_controller (
  // Link to the fabric
  reconfig_if.controller                 link,
  // Configuration straps
  input  wire logic                      continuousWrite,
  input  wire reconfig_pkg::mode_t       mode,
  input  wire logic [3:0]                readLatency,
  input  wire logic                      readPortEnable,
  input  wire logic                      errorEnable,
  // Image memory fetch
  output logic [`IMAGE_ADDR_WIDTH-1:0]   imageAddr,
  output logic                           imageFetch,
  // Channel side write strobe
  output logic                           channelWrite,
  output logic [`WORD_WIDTH-1:0]         channelData
);
  reconfig_pkg::ctrl_state_t state;
  logic [`ANALOG_WIDTH-1:0]  analogReg;
  logic [`ANALOG_WIDTH-1:0]  analogShadow;
  logic [3:0]                latencyCnt;
  logic [1:0]                errorCnt;
  logic                      readPending;
  logic                      lastWord;
  logic                      timerLoad;
  logic [15:0]               timerCount;
  logic                      timerDone;
  logic                      unsupported;

  // Read is meaningful only with analog ports present and analog mode
  function automatic logic readLegal(input reconfig_pkg::mode_t m, input logic en);
    readLegal = en && (m == reconfig_pkg::MODE_ANALOG);
  endfunction : readLegal

  // Any request that the current configuration cannot carry out
  assign unsupported = (link.readReq && !readLegal(mode, readPortEnable))  // RULE_09 RULE_10
                     || (link.writeAll && (mode == reconfig_pkg::MODE_INVALID));

  // Shared timer paces cancellation, analog access and word writes
  always_comb begin
    timerLoad  = 1'b0;
    timerCount = 16'h0000;
    unique case (state)
      reconfig_pkg::ST_POWERUP: begin
        timerLoad  = 1'b1;
        timerCount = `OFFSET_CANCEL_CYC;
      end
      reconfig_pkg::ST_IDLE: begin
        if (!unsupported && (link.writeAll || link.readReq)
            && mode == reconfig_pkg::MODE_ANALOG) begin
          timerLoad  = 1'b1;
          timerCount = {8'h00, `ANALOG_ACCESS_CYC};
        end
      end
      reconfig_pkg::ST_FETCH: begin
        if (latencyCnt == 4'h0) begin
          timerLoad  = 1'b1;
          timerCount = {8'h00, `WORD_WRITE_CYC};
        end
      end
      default: begin
        timerLoad  = 1'b0;
        timerCount = 16'h0000;
      end
    endcase
  end

  pulse_timer phaseTimer (
    .mclk   (link.mclk),
    .resetn (link.resetn),
    .load   (timerLoad),
    .count  (timerCount),
    .done   (timerDone)
  );

  // Main sequencer
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      state <= reconfig_pkg::ST_POWERUP;
    end else begin
      unique case (state)
        reconfig_pkg::ST_POWERUP: state <= reconfig_pkg::ST_CANCEL; // RULE_05
        reconfig_pkg::ST_CANCEL:
          if (timerDone) state <= reconfig_pkg::ST_IDLE;           // RULE_06
        reconfig_pkg::ST_IDLE: begin
          if (unsupported && errorEnable) begin
            state <= reconfig_pkg::ST_ERROR;                       // RULE_13
          end else if (unsupported) begin
            state <= reconfig_pkg::ST_IDLE;
          end else if (link.writeAll || link.readReq) begin       // RULE_01
            if (mode == reconfig_pkg::MODE_ANALOG) state <= reconfig_pkg::ST_ANALOG;
            else if (link.writeAll) state <= reconfig_pkg::ST_FETCH;
          end
        end
        reconfig_pkg::ST_ANALOG:
          if (timerDone) state <= reconfig_pkg::ST_IDLE;
        reconfig_pkg::ST_FETCH:
          if (latencyCnt == 4'h0) state <= reconfig_pkg::ST_WRITE;
        reconfig_pkg::ST_WRITE:
          if (timerDone) begin
            // Continuous mode keeps walking the image on its own
            if (continuousWrite && !lastWord) state <= reconfig_pkg::ST_FETCH; // RULE_02
            else state <= reconfig_pkg::ST_IDLE;                 // RULE_04
          end
        reconfig_pkg::ST_ERROR:
          if (errorCnt == 2'h1) state <= reconfig_pkg::ST_IDLE;
        default: state <= reconfig_pkg::ST_IDLE;
      endcase
    end
  end

  // Image word address; wraps after a full image so the next walk starts clean
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      imageAddr <= '0;
    end else if (state == reconfig_pkg::ST_IDLE && link.writeAll && continuousWrite
                 && !unsupported && mode == reconfig_pkg::MODE_CHANNEL) begin
      // A continuous walk always covers the whole image, whatever regular writes left
      imageAddr <= '0;                                              // RULE_02
    end else if (state == reconfig_pkg::ST_WRITE && timerDone) begin
      imageAddr <= lastWord ? '0 : imageAddr + 1'b1;
    end
  end

  assign lastWord = (imageAddr == `IMAGE_ADDR_WIDTH'(`IMAGE_WORDS - 1));

  // Image fetch latency counter, reloaded per word
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      latencyCnt <= 4'h0;
      imageFetch <= 1'b0;
    end else begin
      imageFetch <= 1'b0;
      if (state != reconfig_pkg::ST_FETCH && (
          (state == reconfig_pkg::ST_IDLE && link.writeAll && !unsupported
           && mode == reconfig_pkg::MODE_CHANNEL) ||
          (state == reconfig_pkg::ST_WRITE && timerDone && continuousWrite && !lastWord))) begin
        // Configured latency applies only in continuous mode; regular fetches use READ_LATENCY_RST
        latencyCnt <= continuousWrite ? readLatency : `READ_LATENCY_RST; // RULE_03
        imageFetch <= 1'b1;
      end else if (state == reconfig_pkg::ST_FETCH && latencyCnt != 4'h0) begin
        latencyCnt <= latencyCnt - 4'h1;
      end
    end
  end

  // Channel write strobe and data, registered
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      channelWrite <= 1'b0;
      channelData  <= '0;
    end else begin
      channelWrite <= (state == reconfig_pkg::ST_FETCH) && (latencyCnt == 4'h0);
      if (state == reconfig_pkg::ST_FETCH && latencyCnt == 4'h0) begin
        channelData <= link.imageWord;
      end
    end
  end

  // Analog setting store and read-back
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      analogReg    <= '0;
      analogShadow <= '0;
      readPending  <= 1'b0;
    end else begin
      if (state == reconfig_pkg::ST_IDLE && link.writeAll && link.analogWrite
          && !unsupported && mode == reconfig_pkg::MODE_ANALOG) begin
        analogShadow <= link.analogIn;
      end
      if (state == reconfig_pkg::ST_IDLE && link.readReq && !unsupported) begin
        readPending <= 1'b1;
      end else if (state == reconfig_pkg::ST_ANALOG && timerDone) begin
        readPending <= 1'b0;
        analogReg   <= analogShadow;
      end
    end
  end

  // Busy follows the sequencer; low in power-up cycle and during error
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      link.busy <= 1'b0;
    end else begin
      unique case (state)
        reconfig_pkg::ST_POWERUP: link.busy <= 1'b1;             // RULE_05
        reconfig_pkg::ST_CANCEL:  link.busy <= !timerDone;        // RULE_06
        reconfig_pkg::ST_IDLE:
          link.busy <= !unsupported && (link.writeAll || link.readReq)
                       && mode != reconfig_pkg::MODE_INVALID;     // RULE_07 RULE_08
        reconfig_pkg::ST_ANALOG:  link.busy <= !timerDone;        // RULE_07
        reconfig_pkg::ST_FETCH:   link.busy <= 1'b1;              // RULE_08
        reconfig_pkg::ST_WRITE:
          link.busy <= !timerDone || (continuousWrite && !lastWord); // RULE_08
        reconfig_pkg::ST_ERROR:   link.busy <= 1'b0;              // RULE_14
        default:                  link.busy <= 1'b0;
      endcase
    end
  end

  // Error held exactly two cycles; data valid one cycle after a read
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      errorCnt       <= 2'h0;
      link.error     <= 1'b0;
      link.dataValid <= 1'b0;
      link.analogOut <= '0;
    end else begin
      if (state == reconfig_pkg::ST_IDLE && unsupported && errorEnable) begin
        errorCnt   <= `ERROR_HOLD_CYC;                            // RULE_14
        link.error <= 1'b1;                                       // RULE_13
      end else if (errorCnt != 2'h0) begin
        errorCnt   <= errorCnt - 2'h1;
        link.error <= (errorCnt != 2'h1);
      end else begin
        link.error <= 1'b0;
      end
      // Valid only when a read port exists; value latched with the flag
      link.dataValid <= readPortEnable && readPending
                        && state == reconfig_pkg::ST_ANALOG && timerDone; // RULE_11 RULE_12
      if (state == reconfig_pkg::ST_ANALOG && timerDone && readPending) begin
        link.analogOut <= analogShadow;                           // RULE_11
      end
    end
  end

  // Analog register drives the transceiver; kept for visibility only here
  logic unusedAnalog;
  assign unusedAnalog = ^analogReg;
endmodule : reconfig_controller

`default_nettype wire

// >>> reconfig_defines.svh
// Timing and sizing constants for the reconfiguration host port
`ifndef RECONFIG_DEFINES_SVH
`define RECONFIG_DEFINES_SVH

`define WORD_WIDTH        16
`define ANALOG_WIDTH      8
`define IMAGE_WORDS       8
`define IMAGE_ADDR_WIDTH  3
`define OFFSET_CANCEL_CYC 16'h0040
`define ANALOG_ACCESS_CYC 8'h04
`define WORD_WRITE_CYC    8'h02
`define READ_LATENCY_RST  4'h1
`define ERROR_HOLD_CYC    2'h2

`endif

// >>> reconfig_pkg.sv
// Types used by the controller and testbench of the reconfiguration host port
`default_nettype none

package reconfig_pkg;

  // Reconfiguration mode chosen by the fabric
  typedef enum logic [1:0] {
    MODE_ANALOG  = 2'h0,
    MODE_CHANNEL = 2'h1,
    MODE_INVALID = 2'h2
  } mode_t;

  // Controller sequencer states
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_CANCEL,
    ST_IDLE,
    ST_ANALOG,
    ST_FETCH,
    ST_WRITE,
    ST_ERROR
  } ctrl_state_t;

endpackage : reconfig_pkg

`default_nettype wire

// >>> reconfig_if.sv
// Interface joining the fabric logic and the reconfiguration controller
`timescale 1ns/1ps
`default_nettype none
`include "reconfig_defines.svh"

interface reconfig_if (
  input wire logic mclk,
  input wire logic resetn
);
  logic                       writeAll;
  logic                       readReq;
  logic                       analogWrite;
  logic [`ANALOG_WIDTH-1:0]   analogIn;
  logic [`WORD_WIDTH-1:0]     imageWord;
  logic                       busy;
  logic                       dataValid;
  logic [`ANALOG_WIDTH-1:0]   analogOut;
  logic                       error;

  modport controller (
    input  mclk, resetn, writeAll, readReq, analogWrite, analogIn, imageWord,
    output busy, dataValid, analogOut, error
  );

  modport fabric (
    input  mclk, resetn, busy, dataValid, analogOut, error,
    output writeAll, readReq, analogWrite, analogIn, imageWord
  );
endinterface : reconfig_if

`default_nettype wire

// >>> pulse_timer.sv
// Loadable down-counter that reports when a timed phase has run out
`timescale 1ns/1ps
`default_nettype none

module pulse_timer (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Control
  input  wire logic        load,
  input  wire logic [15:0] count,
  // Status
  output logic             done
);
  logic [15:0] remain;

  // Count down from the loaded value; done flags the last cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      remain <= 16'h0000;
    end else if (load) begin
      remain <= count;
    end else if (remain != 16'h0000) begin
      remain <= remain - 16'h0001;
    end
  end

  assign done = (remain == 16'h0001) && !load;
endmodule : pulse_timer

`default_nettype wire

// >>> reconfig_fabric.sv
// Fabric end: turns user requests into one-cycle pulses on the link
`timescale 1ns/1ps
`default_nettype none
`include "reconfig_defines.svh"

module reconfig_fabric (
  // Link to the controller
  reconfig_if.fabric                  link,
  // User requests
  input  wire logic                   userWrite,
  input  wire logic                   userRead,
  input  wire logic                   userAnalogWrite,
  input  wire logic [`ANALOG_WIDTH-1:0] userAnalog,
  input  wire logic [`WORD_WIDTH-1:0] userWord,
  // User status
  output logic                        userReady,
  output logic [`ANALOG_WIDTH-1:0]    userReadData,
  output logic                        userReadValid,
  output logic                        userError
);
  logic waitBusy;

  // Pulses last one cycle; no new request while busy or just issued
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      link.writeAll    <= 1'b0;
      link.readReq     <= 1'b0;
      link.analogWrite <= 1'b0;
      link.analogIn    <= '0;
      link.imageWord   <= '0;
      waitBusy         <= 1'b0;
    end else begin
      link.writeAll <= 1'b0;                                     // RULE_01
      link.readReq  <= 1'b0;                                     // RULE_09
      link.imageWord <= userWord;                                // RULE_04
      if (userReady && userWrite) begin                          // RULE_15
        link.writeAll    <= 1'b1;
        link.analogWrite <= userAnalogWrite;
        link.analogIn    <= userAnalog;
        waitBusy         <= 1'b1;
      end else if (userReady && userRead) begin
        link.readReq <= 1'b1;
        waitBusy     <= 1'b1;
      end else if (waitBusy && !link.writeAll && !link.readReq && !link.busy) begin
        waitBusy <= 1'b0;
      end
    end
  end

  // Status toward the user; read data sampled only on valid
  always_ff @(posedge link.mclk or negedge link.resetn) begin
    if (!link.resetn) begin
      userReady     <= 1'b0;
      userReadData  <= '0;
      userReadValid <= 1'b0;
      userError     <= 1'b0;
    end else begin
      userReady <= !link.busy && !waitBusy && !link.writeAll && !link.readReq
                   && !(userReady && (userWrite || userRead));   // RULE_15
      userReadValid <= link.dataValid;                           // RULE_11
      if (link.dataValid) userReadData <= link.analogOut;        // RULE_11
      userError <= link.error;
    end
  end
endmodule : reconfig_fabric

`default_nettype wire

// >>> reconfig_host_assertions.sv
// Concurrent checks on the link between fabric and controller
`timescale 1ns/1ps
`default_nettype none
`include "reconfig_defines.svh"

module reconfig_host_assertions (
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     resetn,
  // Fabric requests
  input wire logic                     writeAll,
  input wire logic                     readReq,
  // Controller status
  input wire logic                     busy,
  input wire logic                     dataValid,
  input wire logic [`ANALOG_WIDTH-1:0] analogOut,
  input wire logic                     error
);
  // ****************
  // Helper counters
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic [7:0] upCnt;
  logic [7:0] busyRun;

  // Edges since reset; saturates so a long run never wraps into the power-up window
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) upCnt <= 8'h00;
    else if (upCnt != 8'hFF) upCnt <= upCnt + 8'h01;
  end

  // Length of the current busy run
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) busyRun <= 8'h00;
    else if (!busy) busyRun <= 8'h00;
    else if (busyRun != 8'hFF) busyRun <= busyRun + 8'h01;
  end

  a_powerup_low: assert property (upCnt == 8'h00 |-> !busy)
    else $error("busy high in first cycle");
  a_cancel_high: assert property ((upCnt >= 8'h01 && upCnt <= 8'h3E) |-> busy)
    else $error("busy dropped during cancel");
  a_write_pulse: assert property (writeAll |=> !writeAll)
    else $error("write request longer than one cycle");
  a_read_pulse: assert property (readReq |=> !readReq)
    else $error("read request longer than one cycle");
  a_request_idle: assert property ((writeAll || readReq) |-> !busy)
    else $error("request issued while busy");
  a_error_two: assert property ($rose(error) |=> error ##1 !error)
    else $error("error not two cycles");
  a_error_idle: assert property (error |-> !busy)
    else $error("busy high with error");
  a_valid_pulse: assert property (dataValid |-> !busy ##1 !dataValid)
    else $error("data valid not a one-cycle end pulse");
  a_readback_hold: assert property ($changed(analogOut) |-> dataValid)
    else $error("read-back changed without data valid");
  a_busy_bounded: assert property (busyRun <= 8'hC8)
    else $error("busy run too long");
endmodule : reconfig_host_assertions

`default_nettype wire

// >>> transceiver_reconfig_host_port_tb_top.sv
// Testbench joining both ends of the reconfiguration host port
`timescale 1ns/1ps
`default_nettype none
`include "reconfig_defines.svh"

module transceiver_reconfig_host_port_tb_top;
  logic                   mclk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   userWrite = 1'b0;
  logic                   userRead = 1'b0;
  logic                   userAnalogWrite = 1'b0;
  logic [7:0]             userAnalog = 8'h00;
  logic [15:0]            userWord = 16'h0000;
  logic                   continuousWrite = 1'b0;
  reconfig_pkg::mode_t    mode = reconfig_pkg::MODE_ANALOG;
  logic [3:0]             readLatency = 4'h1;
  logic                   readPortEnable = 1'b1;
  logic                   errorEnable = 1'b1;
  logic                   userReady, userReadValid, userError, imageFetch, channelWrite;
  logic [7:0]             userReadData;
  logic [2:0]             imageAddr, lastAddr, prevAddr;
  logic [15:0]            channelData, lastData;
  int                     errors = 0, compares = 0, gap = 0, lastGap, gap1;
  int                     wrN, busyN, errN, validN, uvalN, uerrN;
  logic [7:0]             av [2] = '{8'hA5, 8'h3C};
  reconfig_pkg::mode_t    em [4] = '{reconfig_pkg::MODE_INVALID, reconfig_pkg::MODE_CHANNEL,
                                     reconfig_pkg::MODE_ANALOG, reconfig_pkg::MODE_INVALID};
  logic                   er [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic                   rp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic                   ee [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  always #4 mclk = ~mclk;

  reconfig_if reconfig_if_i (.mclk(mclk), .resetn(resetn));
  reconfig_controller reconfig_controller_i (.link(reconfig_if_i),
    .continuousWrite(continuousWrite), .mode(mode), .readLatency(readLatency),
    .readPortEnable(readPortEnable), .errorEnable(errorEnable), .imageAddr(imageAddr),
    .imageFetch(imageFetch), .channelWrite(channelWrite), .channelData(channelData));
  reconfig_fabric reconfig_fabric_i (.link(reconfig_if_i), .userWrite(userWrite),
    .userRead(userRead), .userAnalogWrite(userAnalogWrite), .userAnalog(userAnalog),
    .userWord(userWord), .userReady(userReady), .userReadData(userReadData),
    .userReadValid(userReadValid), .userError(userError));
  reconfig_host_assertions reconfig_host_assertions_i (.mclk(mclk), .resetn(resetn),
    .writeAll(reconfig_if_i.writeAll), .readReq(reconfig_if_i.readReq),
    .busy(reconfig_if_i.busy), .dataValid(reconfig_if_i.dataValid),
    .analogOut(reconfig_if_i.analogOut), .error(reconfig_if_i.error));

  // ****************
  // Monitor and tasks
  // ****************
  // Event counters, cleared by each request so every check sees one transaction
  always @(posedge mclk) begin
    if (channelWrite) begin
      wrN <= wrN + 1;
      lastData <= channelData;
      lastAddr <= imageAddr;
      lastGap <= gap;
    end
    gap <= imageFetch ? 0 : gap + 1;
    busyN <= busyN + int'(reconfig_if_i.busy);
    errN <= errN + int'(reconfig_if_i.error);
    validN <= validN + int'(reconfig_if_i.dataValid);
    uvalN <= uvalN + int'(userReadValid);
    uerrN <= uerrN + int'(userError);
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Idle means ready and not busy; bounded so a hung controller cannot stall the run
  task automatic waitIdle();
    int k;
    k = 0;
    while (!(userReady === 1'b1 && reconfig_if_i.busy === 1'b0) && k < 400) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check("idle reached", 16'h0001, 16'(k < 400));
  endtask : waitIdle

  task automatic setup(input logic cw, input reconfig_pkg::mode_t m, input logic [3:0] lat,
                       input logic rpe, input logic een);
    @(posedge mclk);
    continuousWrite <= cw;
    mode <= m;
    readLatency <= lat;
    readPortEnable <= rpe;
    errorEnable <= een;
  endtask : setup

  // One user request held for a single cycle, then wait for the transaction to settle
  task automatic request(input logic wr, input logic rd, input logic aw,
                         input logic [7:0] a, input logic [15:0] w);
    waitIdle();
    {wrN, busyN, errN, validN, uvalN, uerrN} = '0;
    @(posedge mclk);
    userWrite <= wr;
    userRead <= rd;
    userAnalogWrite <= aw;
    userAnalog <= a;
    userWord <= w;
    @(posedge mclk);
    userWrite <= 1'b0;
    userRead <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    waitIdle();
  endtask : request

  task automatic results();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end

  // ****************
  // Test sequence
  // ****************
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    check("busy first cycle", 16'h0000, 16'(reconfig_if_i.busy));
    @(posedge mclk);
    #1;
    check("busy after first", 16'h0001, 16'(reconfig_if_i.busy));
    gap1 = 1;
    while (reconfig_if_i.busy === 1'b1 && gap1 < 300) begin
      @(posedge mclk);
      #1;
      gap1++;
    end
    check("cancel span", 16'h0001, 16'(gap1 >= 63 && gap1 <= 66));
    $display("test powerup done");
    for (int i = 0; i < 2; i++) begin
      request(1'b1, 1'b0, 1'b1, av[i], 16'h0000);
      check("analog write busy", 16'h0001, 16'(busyN != 0));
      request(1'b0, 1'b1, 1'b0, 8'h00, 16'h0000);
      check("read busy", 16'h0001, 16'(busyN != 0));
      check("valid pulses", 16'h0001, 16'(validN));
      check("user valid", 16'h0001, 16'(uvalN));
      check("read data", {8'h00, av[i]}, {8'h00, userReadData});
    end
    $display("test analog done");
    setup(1'b0, reconfig_pkg::MODE_CHANNEL, 4'h1, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      request(1'b1, 1'b0, 1'b0, 8'h00, 16'h1230 + 16'(i));
      check("word count", 16'h0001, 16'(wrN));
      check("word data", 16'h1230 + 16'(i), lastData);
      check("word busy", 16'h0001, 16'(busyN != 0));
      if (i > 0) check("word addr", {13'h0, prevAddr + 3'h1}, {13'h0, lastAddr});
      prevAddr = lastAddr;
    end
    $display("test regular done");
    foreach (av[i]) begin
      setup(1'b1, reconfig_pkg::MODE_CHANNEL, i ? 4'h5 : 4'h1, 1'b1, 1'b1);
      request(1'b1, 1'b0, 1'b0, 8'h00, 16'hBEEF);
      check("image words", 16'(`IMAGE_WORDS), 16'(wrN));
      check("image data", 16'hBEEF, lastData);
      check("image last addr", 16'(`IMAGE_WORDS - 1), {13'h0, lastAddr});
      if (i) check("latency step", 16'h0004, 16'(lastGap - gap1));
      gap1 = lastGap;
    end
    $display("test continuous done");
    foreach (em[i]) begin
      setup(1'b0, em[i], 4'h1, rp[i], ee[i]);
      request(!er[i], er[i], 1'b0, 8'h00, 16'h0000);
      check("error cycles", ee[i] ? 16'h0002 : 16'h0000, 16'(errN));
      check("error busy", 16'h0000, 16'(busyN));
      check("user error", ee[i] ? 16'h0002 : 16'h0000, 16'(uerrN));
      check("refused read", 16'h0000, 16'(validN));
    end
    $display("test refusals done");
    results();
  end
endmodule : transceiver_reconfig_host_port_tb_top

`default_nettype wire
